// [core/acl_port_range_indirect_bytes.v]
// Indirectly accessed bank of per-port range bound bytes and comparison mode.
`timescale 1ns/10ps
`include "acl_range_defs.vh"

// Summary of operation
// (RULE1) Software sets table select bits 7:5 to 010 before touching rule bytes.
// (RULE2) Control bits 3:0 pick switch port one to four; access goes to that port.
// (RULE3) Offset register picks one rule byte; offset 4 is lower bound high byte.
// (RULE4) Data register returns the selected byte on reads and takes it on writes.
// (RULE5) Upper bound low byte is eight bits, read-write, reset to zero.
// (RULE6) Sixteen-bit lower bound is kept as high and low bytes, each reset to zero.
// (RULE7) Mode 00 off, 01 equals either bound, 10 inside range, 11 outside.
// (RULE8) Data accesses use the latest table, port and offset, with no handshake.
module acl_port_range_indirect_bytes (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register access port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_reg,
  // Matching lookup
  input wire [1:0] match_port,
  input wire [15:0] match_value,
  output reg match_hit_reg
);

  reg [7:0] ctrl_reg;
  reg [7:0] offset_reg;
  reg [7:0] upper_high_mem [0:3];
  reg [7:0] upper_low_mem [0:3];
  reg [7:0] lower_high_mem [0:3];
  reg [7:0] lower_low_mem [0:3];
  reg [1:0] mode_mem [0:3];
  reg [7:0] reg_rdata_next;
  reg [7:0] data_byte;
  wire sel_valid;
  wire [1:0] sel_idx;
  wire hit;
  integer i;
  integer j;

  // Register strobes after address decode.
  wire ctrl_wr;
  wire offset_wr;
  wire data_wr;
  wire data_wr_ok;

  // Lookup view of the rule of the port named by match_port.
  wire [15:0] lower_bound_sel;
  wire [15:0] upper_bound_sel;
  wire [1:0] mode_sel;

  // Accesses with another table or an out-of-range port number touch nothing here.
  function acl_port_ok;
    input [7:0] ctrl;
    begin
      acl_port_ok = (ctrl[`TABLE_SEL_MSB:`TABLE_SEL_LSB] == `TABLE_SEL_ACL) &&
                    (ctrl[`PORT_NUM_MSB:`PORT_NUM_LSB] >= `PORT_NUM_FIRST) &&
                    (ctrl[`PORT_NUM_MSB:`PORT_NUM_LSB] <= `PORT_NUM_LAST);
    end
  endfunction

  // Switch ports are numbered from one; storage is indexed from zero.
  function [1:0] port_index;
    input [7:0] ctrl;
    reg [3:0] diff;
    begin
      diff = ctrl[`PORT_NUM_MSB:`PORT_NUM_LSB] - `PORT_NUM_FIRST;
      port_index = diff[1:0];
    end
  endfunction

  // A write strobe aimed at one register address.
  function wr_to;
    input wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_to = wr && (addr == target);
    end
  endfunction

  // Bounds are stored as two bytes; the compare needs the whole value.
  function [15:0] join_bytes;
    input [7:0] high;
    input [7:0] low;
    begin
      join_bytes = {high, low};
    end
  endfunction

  // The mode sits in bits 2:1 of its byte; the bits around it read as zero.
  function [7:0] mode_to_byte;
    input [1:0] mode;
    begin
      mode_to_byte = 8'h00;
      mode_to_byte[`MODE_MSB:`MODE_LSB] = mode;
    end
  endfunction

  function [1:0] byte_to_mode;
    input [7:0] data;
    begin
      byte_to_mode = data[`MODE_MSB:`MODE_LSB];
    end
  endfunction

  assign sel_valid = acl_port_ok(ctrl_reg); // (RULE1)
  assign sel_idx = port_index(ctrl_reg); // (RULE2)
  assign ctrl_wr = wr_to(reg_wr, reg_addr, `ADDR_IND_CTRL);
  assign offset_wr = wr_to(reg_wr, reg_addr, `ADDR_IND_OFFSET);
  assign data_wr = wr_to(reg_wr, reg_addr, `ADDR_IND_DATA);
  assign data_wr_ok = data_wr && sel_valid; // (RULE2)

  // The lookup reads the stored rule directly, never through the indirect
  // selection, so selecting another port or byte cannot disturb a lookup.
  assign lower_bound_sel = join_bytes(lower_high_mem[match_port], lower_low_mem[match_port]);
  assign upper_bound_sel = join_bytes(upper_high_mem[match_port], upper_low_mem[match_port]);
  assign mode_sel = mode_mem[match_port];

  // Selected byte as seen through the data register.
  always @* begin
    data_byte = 8'h00;
    if (sel_valid) begin
      case (offset_reg) // (RULE3)
        `OFS_UPPER_HIGH: data_byte = upper_high_mem[sel_idx];
        `OFS_UPPER_LOW: data_byte = upper_low_mem[sel_idx]; // (RULE5)
        `OFS_LOWER_HIGH: data_byte = lower_high_mem[sel_idx]; // (RULE6)
        `OFS_LOWER_LOW: data_byte = lower_low_mem[sel_idx]; // (RULE6)
        `OFS_RULE_SIX: data_byte = mode_to_byte(mode_mem[sel_idx]);
        default: data_byte = 8'h00;
      endcase
    end
  end

  // Unmapped addresses read as zero.
  always @* begin
    case (reg_addr)
      `ADDR_IND_CTRL: reg_rdata_next = ctrl_reg;
      `ADDR_IND_OFFSET: reg_rdata_next = offset_reg;
      `ADDR_IND_DATA: reg_rdata_next = data_byte; // (RULE4)
      default: reg_rdata_next = 8'h00;
    endcase
  end

  // Control and offset registers; the data path reads them directly, so a write
  // takes effect for the very next data access.
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= 8'h00;
      offset_reg <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= reg_wdata; // (RULE8)
      end
      if (offset_wr) begin
        offset_reg <= reg_wdata; // (RULE8)
      end
    end
  end

  // Read data is loaded only by a read strobe and then stands until the next read.
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_reg <= reg_rdata_next; // (RULE4)
    end
  end

  // Rule byte storage, one set per switch port. Every byte clears on reset, so a
  // port that software never set up cannot match anything.
  always @(posedge clk_sys) begin
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        upper_high_mem[i] <= `BYTE_RESET;
        upper_low_mem[i] <= `BYTE_RESET; // (RULE5)
        lower_high_mem[i] <= `BYTE_RESET; // (RULE6)
        lower_low_mem[i] <= `BYTE_RESET; // (RULE6)
      end
    end else if (data_wr_ok) begin
      case (offset_reg) // (RULE4)
        `OFS_UPPER_HIGH: upper_high_mem[sel_idx] <= reg_wdata;
        `OFS_UPPER_LOW: upper_low_mem[sel_idx] <= reg_wdata; // (RULE5)
        `OFS_LOWER_HIGH: lower_high_mem[sel_idx] <= reg_wdata; // (RULE6)
        `OFS_LOWER_LOW: lower_low_mem[sel_idx] <= reg_wdata; // (RULE6)
        default: ;
      endcase
    end
  end

  // The comparison mode keeps only its two bits; the rest of its byte is not stored.
  always @(posedge clk_sys) begin
    if (rst) begin
      for (j = 0; j < 4; j = j + 1) begin
        mode_mem[j] <= `MODE_RESET;
      end
    end else if (data_wr_ok && (offset_reg == `OFS_RULE_SIX)) begin
      mode_mem[sel_idx] <= byte_to_mode(reg_wdata); // (RULE7)
    end
  end

  // The compare sees the bytes as they stand; a bound rewritten one byte at a
  // time is half new for at least two cycles, which software must allow for.
  range_compare cmp (
    .value(match_value),
    .lower_bound(lower_bound_sel),
    .upper_bound(upper_bound_sel),
    .port_compare_mode(mode_sel),
    .hit(hit)
  );

  // The result is registered so the output does not ripple with bound writes.
  always @(posedge clk_sys) begin
    if (rst) begin
      match_hit_reg <= 1'b0;
    end else begin
      match_hit_reg <= hit; // (RULE7)
    end
  end

endmodule

// [common/acl_range_defs.vh]
// Register addresses, field positions, reset values and encodings for the rule byte bank.
`ifndef ACL_RANGE_DEFS_VH
`define ACL_RANGE_DEFS_VH

`define ADDR_IND_CTRL 8'h6E
`define ADDR_IND_OFFSET 8'h6F
`define ADDR_IND_DATA 8'hA0

`define TABLE_SEL_MSB 7
`define TABLE_SEL_LSB 5
`define TABLE_SEL_ACL 3'h2
`define PORT_NUM_MSB 3
`define PORT_NUM_LSB 0
`define PORT_NUM_FIRST 4'h1
`define PORT_NUM_LAST 4'h4

`define OFS_UPPER_HIGH 8'h02
`define OFS_UPPER_LOW 8'h03
`define OFS_LOWER_HIGH 8'h04
`define OFS_LOWER_LOW 8'h05
`define OFS_RULE_SIX 8'h06

`define MODE_MSB 2
`define MODE_LSB 1
`define MODE_OFF 2'h0
`define MODE_EITHER 2'h1
`define MODE_INSIDE 2'h2
`define MODE_OUTSIDE 2'h3

`define BYTE_RESET 8'h00
`define MODE_RESET 2'h0

`endif

// [core/range_compare.v]
// Combinational port-number comparison against a minimum and maximum bound.
`timescale 1ns/10ps
`include "acl_range_defs.vh"

module range_compare (
  // Value under test and bounds
  input wire [15:0] value,
  input wire [15:0] lower_bound,
  input wire [15:0] upper_bound,
  // Comparison mode and result
  input wire [1:0] port_compare_mode,
  output reg hit
);

  always @* begin
    case (port_compare_mode) // (RULE7)
      `MODE_OFF: hit = 1'b0;
      `MODE_EITHER: hit = (value == upper_bound) || (value == lower_bound);
      `MODE_INSIDE: hit = (value >= lower_bound) && (value <= upper_bound);
      `MODE_OUTSIDE: hit = (value < lower_bound) || (value > upper_bound);
      default: hit = 1'b0;
    endcase
  end

endmodule

// [testbench/range_bank_monitor.sv]
// Checker for the rule byte bank ports.
`timescale 1ns/10ps
`include "acl_range_defs.vh"
module range_bank_monitor (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register and lookup ports
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_reg,
  input wire [1:0] match_port,
  input wire [15:0] match_value,
  input wire match_hit_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg [7:0] ctrl_reg, ofs_reg;
  wire rd = reg_rd && !reg_wr;
  wire port_ok = ctrl_reg[3:0] >= `PORT_NUM_FIRST && ctrl_reg[3:0] <= `PORT_NUM_LAST;
  wire ofs_ok = ofs_reg >= `OFS_UPPER_HIGH && ofs_reg <= `OFS_LOWER_LOW;
  wire acl = ctrl_reg[7:5] == `TABLE_SEL_ACL;
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= 8'h00;
      ofs_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_IND_CTRL) ctrl_reg <= reg_wdata;
      if (reg_addr == `ADDR_IND_OFFSET) ofs_reg <= reg_wdata;
    end
  end
  AST_RST_RDATA: assert property ($fell(rst) |-> reg_rdata_reg == 8'h00)
    else $error("read data not clear");
  AST_RST_HIT: assert property ($fell(rst) |-> !match_hit_reg)
    else $error("hit not clear");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata_reg))
    else $error("read data moved");
  AST_UNMAPPED: assert property (rd && reg_addr == 8'h55 |=> reg_rdata_reg == 8'h00)
    else $error("unmapped read");
  AST_BAD_TABLE: assert property (rd && reg_addr == `ADDR_IND_DATA && !acl |=>
    reg_rdata_reg == 8'h00) else $error("wrong table read");
  AST_BAD_PORT: assert property (rd && reg_addr == `ADDR_IND_DATA && !port_ok |=>
    reg_rdata_reg == 8'h00) else $error("wrong port read");
  AST_CTRL_RB: assert property (reg_wr && !reg_rd && reg_addr == `ADDR_IND_CTRL ##1
    rd && reg_addr == `ADDR_IND_CTRL |=> reg_rdata_reg == $past(reg_wdata, 2))
    else $error("control readback");
  AST_WR_RD: assert property (reg_wr && reg_addr == `ADDR_IND_DATA && acl && port_ok
    && ofs_ok ##1 rd && reg_addr == `ADDR_IND_DATA |=> reg_rdata_reg == $past(reg_wdata, 2))
    else $error("data readback");
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the rule byte bank.
`timescale 1ns/10ps
`include "acl_range_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  reg clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  reg [1:0] match_port = 2'h1;
  reg [15:0] match_value = 16'h0000;
  reg [11:0] hit_map = 12'h8C8;
  wire [7:0] reg_rdata_reg;
  wire match_hit_reg;
  integer bad_count = 0, tests_run = 0, cyc = 0, p, o, m, k;
  acl_port_range_indirect_bytes uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg),
    .match_port(match_port), .match_value(match_value), .match_hit_reg(match_hit_reg));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin bad_count++; give_verdict; end
  end
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // Strobes stay up until the next call, so no signal is set twice in one step.
  task acc(input w, input r, input [7:0] a, input [7:0] d);
    begin reg_wr = w; reg_rd = r; reg_addr = a; reg_wdata = d; @(negedge clk_sys); end
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    begin acc(0, 1, a, 8'h00); `CHK("rd", e, reg_rdata_reg) end
  endtask
  task sel(input [7:0] c, input [7:0] f);
    begin acc(1, 0, `ADDR_IND_CTRL, c); acc(1, 0, `ADDR_IND_OFFSET, f); end
  endtask
  task t_reset;
    begin
      acc(1, 0, `ADDR_IND_CTRL, 8'h41);
      rdchk(`ADDR_IND_CTRL, 8'h41);
      for (o = 2; o < 7; o++) begin
        acc(1, 0, `ADDR_IND_OFFSET, o[7:0]);
        rdchk(`ADDR_IND_DATA, 8'h00);
      end
    end
  endtask
  task t_rw;
    begin
      for (p = 1; p < 5; p++) for (o = 2; o < 6; o++) begin
        sel(8'h40 | p[7:0], o[7:0]);
        acc(1, 0, `ADDR_IND_DATA, 8'(p * 16 + o));
        rdchk(`ADDR_IND_DATA, 8'(p * 16 + o));
      end
      for (p = 1; p < 5; p++) for (o = 2; o < 6; o++) begin
        sel(8'h40 | p[7:0], o[7:0]);
        rdchk(`ADDR_IND_DATA, 8'(p * 16 + o));
      end
    end
  endtask
  task t_refuse;
    begin
      sel(8'h61, 8'h03);
      rdchk(`ADDR_IND_DATA, 8'h00);
      sel(8'h45, 8'h03);
      acc(1, 0, `ADDR_IND_DATA, 8'hEE);
      rdchk(`ADDR_IND_DATA, 8'h00);
      sel(8'h41, 8'h03);
      rdchk(`ADDR_IND_DATA, 8'h13);
      rdchk(8'h55, 8'h00);
    end
  endtask
  task t_match;
    begin
      for (o = 2; o < 6; o++) begin
        sel(8'h42, o[7:0]);
        acc(1, 0, `ADDR_IND_DATA, o == 3 ? 8'h20 : o == 5 ? 8'h10 : 8'h00);
      end
      for (m = 0; m < 4; m++) begin
        sel(8'h42, `OFS_RULE_SIX);
        acc(1, 0, `ADDR_IND_DATA, 8'(m * 2));
        rdchk(`ADDR_IND_DATA, 8'(m * 2));
        for (k = 0; k < 3; k++) begin
          match_value = k == 0 ? 16'h0010 : k == 1 ? 16'h0015 : 16'h0030;
          acc(0, 0, 8'h00, 8'h00);
          `CHK("hit", hit_map[m * 3 + k], match_hit_reg)
        end
      end
      match_port = 2'h2;
      acc(0, 0, 8'h00, 8'h00);
      `CHK("hit", 1'b0, match_hit_reg)
    end
  endtask
  task t_rst2;
    begin
      match_port = 2'h1;
      sel(8'h41, `OFS_UPPER_LOW);
      acc(1, 0, `ADDR_IND_DATA, 8'h5A);
      `CHK("hit", 1'b1, match_hit_reg)
      rst = 1;
      acc(0, 0, 8'h00, 8'h00);
      acc(0, 0, 8'h00, 8'h00);
      rst = 0;
      rdchk(`ADDR_IND_CTRL, 8'h00);
      `CHK("hit", 1'b0, match_hit_reg)
      sel(8'h41, `OFS_UPPER_LOW);
      rdchk(`ADDR_IND_DATA, 8'h00);
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 0;
    t_reset;
    t_rw;
    t_refuse;
    t_match;
    t_rst2;
    give_verdict;
  end
endmodule
bind acl_port_range_indirect_bytes range_bank_monitor mon (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata_reg(reg_rdata_reg), .match_port(match_port), .match_value(match_value),
  .match_hit_reg(match_hit_reg));
